/* logic/dics_device.sv */
// Command slave of a 64-step digital potentiometer on a two-wire bus.
// Assumes a single master that holds each clock level for many mclk cycles.
// What this block does
// - Nine addresses from two three-state straps.
// - Address, instruction, data bytes, each acknowledged.
// - Decode command field into six actions.
// - Latch write loads six low data bits.
// - Command one, pointer zero programs stored copy.
// - Unprogrammed stored copy presents midscale.
// - Protect command: data bit zero sets protection.
// - Store or restore has no data byte.
// - Read: pointer write, repeated start, read address.
// - Pointer survives between transactions for direct reads.
// - Readback byte carries six-bit setting, master no-acks.
// - Tolerance bytes at pointers 11110 and 11111.
// - Sign bit on top, integer percent below.
// - Second tolerance byte is pure fraction.
// - Each tolerance byte readable individually.
// - Consecutive reads step pointer 11110 to 11111.
// - Straps captured once after reset, then fixed.
// - Further latch data bytes update latch until stop.
// - Outgoing data bits change on clock fall.
`timescale 1ns/1ns
`default_nettype none
module dics_device
  import dics_pkg::*;
#(
  parameter logic [7:0] TOL_SIGN_INT = TOL_SIGN_INT_DEFAULT,
  parameter logic [7:0] TOL_FRACTION = TOL_FRACTION_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  dics_if.dev bus,
  input wire logic [1:0] strapLo,
  input wire logic [1:0] strapHi,
  output logic [5:0] wiperPos,
  output logic [5:0] storedWiper,
  output logic protect
);
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_RX = 5'b00010,
    D_ACK = 5'b00100,
    D_TX = 5'b01000,
    D_MACK = 5'b10000
  } dics_dev_e;

  typedef struct packed {
    dics_dev_e fsm;
    logic [1:0] settle;
    logic strapped;
    logic [6:0] ownAddr;
    logic sclPrev;
    logic sdaPrev;
    logic [7:0] sh;
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic rw;
    logic [2:0] cmd;
    logic [4:0] ptr;
    logic [5:0] latch;
    logic [5:0] stored;
    logic prot;
    logic sdaLow;
    logic mAck;
  } dics_dev_s;

  dics_dev_s st;
  dics_dev_s next_st;
  logic [5:0] pins;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [4:0] nextPtr;
  logic [7:0] outByte;

  // ==========================================================================
  // Address decode from the strap states
  function automatic logic [6:0] strapAddr(input logic [1:0] lo,
                                           input logic [1:0] hi);
    logic [6:0] base;
    logic [6:0] step;
    base = (lo == STRAP_HIGH) ? ADDR_LO_HIGH :
           (lo == STRAP_FLOAT) ? ADDR_LO_FLOAT : ADDR_LO_LOW;
    step = (hi == STRAP_HIGH) ? ADDR_HI_HIGH_STEP :
           (hi == STRAP_FLOAT) ? ADDR_HI_FLOAT_STEP : 7'h00;
    return 7'(base + step);
  endfunction
  // ==========================================================================
  // Byte returned for a pointer and command
  function automatic logic [7:0] readByte(input logic [2:0] cmd,
                                          input logic [4:0] ptr,
                                          input logic [5:0] latch,
                                          input logic [5:0] stored);
    // Tolerance bytes win whatever the command field says
    if (ptr == PTR_TOL_SIGN) begin
      return TOL_SIGN_INT;
    end else if (ptr == PTR_TOL_FRAC) begin
      return TOL_FRACTION;
    end else if (cmd == CMD_STORED) begin
      return {2'h0, stored};
    end
    return {2'h0, latch};
  endfunction
  // ==========================================================================
  // Pins cross into mclk through two flops
  dics_sync #(
    .WIDTH(6)
  ) pinSync (
    .mclk(mclk),
    .rst(rst),
    .din({bus.scl, bus.sda, strapLo, strapHi}),
    .dout(pins)
  );
  assign sclS = pins[5];
  assign sdaS = pins[4];
  // ==========================================================================
  // Bus conditions from the synchronised lines
  always_comb begin
    sclRise = sclS && !st.sclPrev;
    sclFall = !sclS && st.sclPrev;
    startSeen = sclS && st.sclPrev && st.sdaPrev && !sdaS;
    stopSeen = sclS && st.sclPrev && !st.sdaPrev && sdaS;
    // Pointer steps only from the first tolerance byte after a master ack
    nextPtr = (st.fsm == D_MACK && st.ptr == PTR_TOL_SIGN) ? PTR_TOL_FRAC :
              st.ptr;
    outByte = readByte(st.cmd, nextPtr, st.latch, st.stored);
  end
  // ==========================================================================
  // Slave state machine
  always_comb begin
    next_st = st;
    next_st.sclPrev = sclS;
    next_st.sdaPrev = sdaS;
    // Straps are read once the synchroniser has filled
    if (!st.strapped) begin
      next_st.settle = 2'(st.settle + 2'h1);
      if (st.settle == 2'h3) begin
        next_st.strapped = 1'b1;
        next_st.ownAddr = strapAddr(pins[3:2], pins[1:0]);
      end
    end
    if (startSeen) begin
      // A repeated start also lands here and keeps the pointer
      next_st.fsm = D_RX;
      next_st.bitCnt = 4'h0;
      next_st.byteIdx = 2'h0;
      next_st.sdaLow = 1'b0;
    end else if (stopSeen) begin
      next_st.fsm = D_IDLE;
      next_st.sdaLow = 1'b0;
    end else begin
      unique case (st.fsm)
        D_IDLE: next_st.sdaLow = 1'b0;
        D_RX: begin
          if (sclRise) begin
            next_st.sh = {st.sh[6:0], sdaS};
            next_st.bitCnt = 4'(st.bitCnt + 4'h1);
          end
          if (sclFall && st.bitCnt == 4'h8) begin
            next_st.fsm = D_ACK;
            next_st.sdaLow = 1'b1;
            if (st.byteIdx == 2'h0) begin
              if (st.strapped && st.sh[7:1] == st.ownAddr) begin
                next_st.rw = st.sh[0];
              end else begin
                next_st.fsm = D_IDLE;
                next_st.sdaLow = 1'b0;
              end
            end else if (st.byteIdx == 2'h1) begin
              next_st.cmd = st.sh[7:5];
              next_st.ptr = st.sh[4:0];
              // Store and restore run on the instruction alone
              if (st.sh[7:5] == CMD_RESTORE) begin
                next_st.latch = st.stored;
              end
              if (st.sh[7:5] == CMD_STORE && !st.prot) begin
                next_st.stored = st.latch;
              end
            end else begin
              unique case (st.cmd)
                CMD_LATCH: begin
                  next_st.latch = st.sh[5:0];
                end
                CMD_STORED: begin
                  if (st.ptr == PTR_NV_WIPER && !st.prot) begin
                    next_st.stored = st.sh[5:0];
                  end
                end
                CMD_PROTECT: begin
                  next_st.prot = st.sh[0];
                end
                default: begin
                  // Nop, store, restore and spare codes ignore data
                  next_st.prot = st.prot;
                end
              endcase
            end
            if (st.byteIdx != 2'h2) begin
              next_st.byteIdx = 2'(st.byteIdx + 2'h1);
            end
          end
        end
        D_ACK: begin
          // Loading sh before a written byte is harmless: it is shifted out
          if (sclFall) begin
            next_st.bitCnt = 4'h0;
            next_st.fsm = st.rw ? D_TX : D_RX;
            next_st.sh = outByte;
            next_st.sdaLow = st.rw && !outByte[7];
          end
        end
        D_TX: begin
          if (sclRise) begin
            next_st.bitCnt = 4'(st.bitCnt + 4'h1);
          end
          if (sclFall) begin
            if (st.bitCnt == 4'h8) begin
              next_st.fsm = D_MACK;
              next_st.sdaLow = 1'b0;
            end else begin
              next_st.sh = {st.sh[6:0], 1'b0};
              next_st.sdaLow = !st.sh[6];
            end
          end
        end
        D_MACK: begin
          if (sclRise) begin
            next_st.mAck = !sdaS;
          end
          if (sclFall) begin
            if (st.mAck) begin
              // Master wants more: send the next byte at once
              next_st.ptr = nextPtr;
              next_st.sh = outByte;
              next_st.sdaLow = !outByte[7];
              next_st.bitCnt = 4'h0;
              next_st.fsm = D_TX;
            end else begin
              next_st.fsm = D_IDLE;
            end
          end
        end
      endcase
    end
  end
  // ==========================================================================
  // State register; wiper copies start at midscale
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.fsm <= D_IDLE;
      st.latch <= WIPER_MIDSCALE;
      st.stored <= WIPER_MIDSCALE;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================================================
  // Outputs straight from state
  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe = st.sdaLow;
  assign wiperPos = st.latch;
  assign storedWiper = st.stored;
  assign protect = st.prot;
endmodule
`default_nettype wire

/* common/dics_pkg.sv */
// Shared constants for the potentiometer command slave and its bus master.
// Assumes both ends and the register bus run on one 25 MHz clock.
package dics_pkg;

  // ==========================================================================
  // Strap pin encoding and bus address decode
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [6:0] ADDR_LO_LOW = 7'h18;
  localparam logic [6:0] ADDR_LO_FLOAT = 7'h29;
  localparam logic [6:0] ADDR_LO_HIGH = 7'h4c;
  localparam logic [6:0] ADDR_HI_FLOAT_STEP = 7'h01;
  localparam logic [6:0] ADDR_HI_HIGH_STEP = 7'h02;

  // ==========================================================================
  // Command field codes and pointer values
  localparam logic [2:0] CMD_LATCH = 3'h0;
  localparam logic [2:0] CMD_STORED = 3'h1;
  localparam logic [2:0] CMD_PROTECT = 3'h2;
  localparam logic [2:0] CMD_NOP = 3'h4;
  localparam logic [2:0] CMD_RESTORE = 3'h5;
  localparam logic [2:0] CMD_STORE = 3'h6;
  localparam logic [4:0] PTR_NV_WIPER = 5'h00;
  localparam logic [4:0] PTR_TOL_SIGN = 5'h1e;
  localparam logic [4:0] PTR_TOL_FRAC = 5'h1f;

  // ==========================================================================
  // Reset values
  localparam logic [5:0] WIPER_MIDSCALE = 6'h20;
  localparam logic [7:0] TOL_SIGN_INT_DEFAULT = 8'h00;
  localparam logic [7:0] TOL_FRACTION_DEFAULT = 8'h00;

  // ==========================================================================
  // Serial clock timing: four phases per bit
  localparam int MCLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 320;
  localparam logic [1:0] PHASE_LAST =
    2'(SCL_PERIOD_NS / (4 * MCLK_PERIOD_NS) - 1);

  // ==========================================================================
  // Controller register map, byte addresses, and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h8;
  localparam int CTRL_DEV_LSB = 0;
  localparam int CTRL_TWO_BIT = 7;
  localparam int CTRL_INSTR_LSB = 8;
  localparam int CTRL_DATA_LSB = 16;
  localparam int CTRL_OP_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CMD = 2'h1;
  localparam logic [1:0] OP_SETREAD = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

endpackage

/* common/dics_if.sv */
// Two-wire link between the bus master and the potentiometer slave.
// Both data drivers are open drain; the master alone drives the clock.
`timescale 1ns/1ns
`default_nettype none
interface dics_if;
  logic scl;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sda;

  // ==========================================================================
  // Wired-AND data line with pull-up
  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

  modport host (output scl, output sdaHostOut, output sdaHostOe, input sda);
  modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
endinterface
`default_nettype wire

/* logic/dics_sync.sv */
// Two flip-flop synchroniser for pins from outside the mclk domain.
// Assumes the inputs are quasi-static relative to mclk.
`timescale 1ns/1ns
`default_nettype none
module dics_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dics_sync_s;

  dics_sync_s st;
  dics_sync_s next_st;

  // ==========================================================================
  // First stage feeds only the second one
  always_comb begin
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;
endmodule
`default_nettype wire

/* logic/dics_host.sv */
// Two-wire bus master that issues potentiometer transactions for software.
// Assumes Avalon-MM requests on mclk and a slave that never stretches scl.
`timescale 1ns/1ns
`default_nettype none
module dics_host
  import dics_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  dics_if.host bus,
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  output logic [31:0] avReadData,
  output logic avWaitRequest
);
  typedef enum logic [9:0] {
    H_IDLE = 10'b0000000001,
    H_START = 10'b0000000010,
    H_ADDRW = 10'b0000000100,
    H_INSTR = 10'b0000001000,
    H_DATA = 10'b0000010000,
    H_RSTART = 10'b0000100000,
    H_ADDRR = 10'b0001000000,
    H_RD1 = 10'b0010000000,
    H_RD2 = 10'b0100000000,
    H_STOP = 10'b1000000000
  } dics_hst_e;

  typedef struct packed {
    dics_hst_e fsm;
    logic waitReq;
    logic [31:0] rdata;
    logic busy;
    logic nack;
    logic [1:0] op;
    logic two;
    logic [6:0] dev;
    logic [7:0] instr;
    logic [7:0] data;
    logic [15:0] rx;
    logic [7:0] sh;
    logic [1:0] phase;
    logic [1:0] tick;
    logic [3:0] bitCnt;
    logic scl;
    logic sdaLow;
  } dics_hst_s;

  dics_hst_s st;
  dics_hst_s next_st;
  logic sdaS;
  logic isTx;
  logic isByte;
  dics_hst_e nx;

  // ==========================================================================
  // Successor of each transaction step
  function automatic dics_hst_e nextStep(input dics_hst_e s,
                                         input logic [1:0] op,
                                         input logic two);
    unique case (s)
      H_IDLE: return H_IDLE;
      H_START: return (op == OP_READ) ? H_ADDRR : H_ADDRW;
      H_ADDRW: return H_INSTR;
      H_INSTR: return (op == OP_WRITE) ? H_DATA :
                      (op == OP_SETREAD) ? H_RSTART : H_STOP;
      H_DATA: return H_STOP;
      H_RSTART: return H_ADDRR;
      H_ADDRR: return H_RD1;
      H_RD1: return two ? H_RD2 : H_STOP;
      H_RD2: return H_STOP;
      H_STOP: return H_IDLE;
    endcase
  endfunction

  // ==========================================================================
  // Byte sent in a step
  function automatic logic [7:0] stepByte(input dics_hst_e s,
                                          input dics_hst_s c);
    if (s == H_ADDRW) begin
      return {c.dev, 1'b0};
    end else if (s == H_ADDRR) begin
      return {c.dev, 1'b1};
    end else if (s == H_INSTR) begin
      return c.instr;
    end else begin
      return c.data;
    end
  endfunction

  // ==========================================================================
  // Clock and data levels as {scl, sdaLow} for a step and phase
  function automatic logic [1:0] lines(input dics_hst_s c);
    logic low;
    low = 1'b0;
    if (c.fsm inside {H_ADDRW, H_INSTR, H_DATA, H_ADDRR}) begin
      low = (c.bitCnt != 4'h8) && !c.sh[7];
    end else if (c.fsm == H_RD1) begin
      low = (c.bitCnt == 4'h8) && c.two;
    end
    unique case (c.fsm)
      H_IDLE: return 2'b10;
      H_START: return (c.phase == 2'h0) ? 2'b10 :
                      (c.phase == 2'h1) ? 2'b11 : 2'b01;
      H_RSTART: return (c.phase == 2'h0) ? 2'b00 :
                       (c.phase == 2'h1) ? 2'b10 :
                       (c.phase == 2'h2) ? 2'b11 : 2'b01;
      H_STOP: return (c.phase == 2'h0) ? 2'b01 :
                     (c.phase == 2'h1) ? 2'b11 : 2'b10;
      H_ADDRW, H_INSTR, H_DATA, H_ADDRR, H_RD1, H_RD2:
        return {c.phase == 2'h1 || c.phase == 2'h2, low};
    endcase
  endfunction

  dics_sync #(
    .WIDTH(1)
  ) sdaSync (
    .mclk(mclk),
    .rst(rst),
    .din(bus.sda),
    .dout(sdaS)
  );

  // ==========================================================================
  // Register slave and bit sequencer
  always_comb begin
    next_st = st;
    nx = H_IDLE;
    isTx = st.fsm inside {H_ADDRW, H_INSTR, H_DATA, H_ADDRR};
    isByte = isTx || st.fsm == H_RD1 || st.fsm == H_RD2;
    next_st.waitReq = 1'b1;
    // One wait cycle per access keeps read data registered
    if ((avRead || avWrite) && st.waitReq) begin
      next_st.waitReq = 1'b0;
      next_st.rdata = 32'h0;
      if (avAddress == REG_CTRL) begin
        next_st.rdata = {6'h0, st.op, st.data, st.instr, st.two, st.dev};
      end else if (avAddress == REG_STATUS) begin
        next_st.rdata[STAT_BUSY_BIT] = st.busy;
        next_st.rdata[STAT_NACK_BIT] = st.nack;
      end else if (avAddress == REG_RDATA) begin
        next_st.rdata = {16'h0, st.rx};
      end
      // Writes while busy are dropped
      if (avWrite && avAddress == REG_CTRL && !st.busy) begin
        next_st.dev = avWriteData[CTRL_DEV_LSB +: 7];
        next_st.two = avWriteData[CTRL_TWO_BIT];
        next_st.instr = avWriteData[CTRL_INSTR_LSB +: 8];
        next_st.data = avWriteData[CTRL_DATA_LSB +: 8];
        next_st.op = avWriteData[CTRL_OP_LSB +: 2];
        next_st.busy = 1'b1;
        next_st.nack = 1'b0;
        next_st.rx = 16'h0;
        next_st.fsm = H_START;
        next_st.phase = 2'h0;
        next_st.tick = 2'h0;
      end
    end
    if (st.fsm != H_IDLE) begin
      next_st.tick = 2'(st.tick + 2'h1);
      if (st.tick == PHASE_LAST) begin
        next_st.tick = 2'h0;
        next_st.phase = 2'(st.phase + 2'h1);
        // Sample late in the high phase, well after the slave settles
        if (st.phase == 2'h2 && isByte) begin
          if (st.bitCnt != 4'h8) begin
            next_st.rx = {st.rx[14:0], sdaS};
          end else if (isTx && sdaS) begin
            next_st.nack = 1'b1;
          end
        end
        if (st.phase == 2'h3) begin
          if (isByte && st.bitCnt != 4'h8) begin
            next_st.bitCnt = 4'(st.bitCnt + 4'h1);
            next_st.sh = {st.sh[6:0], 1'b0};
          end else begin
            nx = (isTx && st.nack) ? H_STOP :
                 nextStep(st.fsm, st.op, st.two);
            next_st.fsm = nx;
            next_st.sh = stepByte(nx, st);
            next_st.bitCnt = 4'h0;
            if (nx == H_IDLE) begin
              next_st.busy = 1'b0;
            end
          end
        end
      end
    end
    {next_st.scl, next_st.sdaLow} = lines(next_st);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.fsm <= H_IDLE;
      st.waitReq <= 1'b1;
      st.scl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs straight from state
  assign bus.scl = st.scl;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOe = st.sdaLow;
  assign avReadData = st.rdata;
  assign avWaitRequest = st.waitReq;
endmodule
`default_nettype wire

/* tb/dics_monitor.sv */
// Checker of the two-wire link between host and device.
// Assumes it sits beside the interface and samples on mclk.
`timescale 1ns/1ns
`default_nettype none
module dics_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe
);
  // ==========================================================
  // Link rules, all in the mclk domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_devOd; sdaDevOe |-> !sdaDevOut; endproperty
  property p_hostOd; sdaHostOe |-> !sdaHostOut; endproperty
  // Device moves data only well inside the low clock phase
  property p_devEdge;
    $changed(sdaDevOe) |-> !scl && !$past(scl, 2);
  endproperty
  property p_sclHigh; $rose(scl) |-> scl [*2]; endproperty
  property p_sclLow; $fell(scl) |-> !scl [*2]; endproperty
  property p_wireLow; (sdaDevOe || sdaHostOe) |-> !sda; endproperty
  property p_wireHigh; !(sdaDevOe || sdaHostOe) |-> sda; endproperty
  property p_relIdle; $fell(rst) |-> scl && !sdaDevOe; endproperty
  a_devOd: assert property (p_devOd) else $error("dev drives high");
  a_hostOd: assert property (p_hostOd) else $error("host drives high");
  a_devEdge: assert property (p_devEdge) else $error("dev bit late");
  a_sclHigh: assert property (p_sclHigh) else $error("short high");
  a_sclLow: assert property (p_sclLow) else $error("short low");
  a_wireLow: assert property (p_wireLow) else $error("wire not low");
  a_wireHigh: assert property (p_wireHigh) else $error("wire low");
  a_relIdle: assert property (p_relIdle) else $error("link busy");
  c_ack: cover property ($rose(sdaDevOe));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

/* tb/test_digipot_i2c_command_slave.sv */
// Bench joining host and device over the link, driven by Avalon-MM.
// Assumes one 25 MHz mclk for both ends and the checker.
`timescale 1ns/1ns
`default_nettype none
module test_digipot_i2c_command_slave;
  import dics_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  localparam logic [6:0] DEV = 7'h2b;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] strapLo = STRAP_FLOAT;
  logic [1:0] strapHi = STRAP_HIGH;
  logic [3:0] avAddress = 4'h0;
  logic avRead = 1'b0;
  logic avWrite = 1'b0;
  logic [31:0] avWriteData = 32'h0;
  logic [31:0] avReadData;
  logic avWaitRequest;
  logic [5:0] wiperPos;
  logic [5:0] storedWiper;
  logic protect;
  logic [31:0] rd;
  logic [31:0] st;
  logic [7:0] no_operation [3] = '{8'h80, 8'h60, 8'he0};
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  dics_if link ();
  dics_device #(.TOL_SIGN_INT(8'h9c), .TOL_FRACTION(8'h0f)) u_dics_device (
    .mclk(mclk), .rst(rst), .bus(link), .strapLo(strapLo),
    .strapHi(strapHi), .wiperPos(wiperPos), .storedWiper(storedWiper),
    .protect(protect));
  dics_host u_dics_host (.mclk(mclk), .rst(rst), .bus(link),
    .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWriteData(avWriteData), .avReadData(avReadData),
    .avWaitRequest(avWaitRequest));
  dics_monitor u_dics_monitor (.mclk(mclk), .rst(rst), .scl(link.scl),
    .sda(link.sda), .sdaHostOut(link.sdaHostOut),
    .sdaHostOe(link.sdaHostOe), .sdaDevOut(link.sdaDevOut),
    .sdaDevOe(link.sdaDevOe));
  initial begin
    forever #20 mclk = ~mclk;
  end
  // Hang guard: the whole run needs far fewer cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    avAddress <= a;
    avWriteData <= d;
    avWrite <= w;
    avRead <= !w;
    @(posedge mclk);
    while (avWaitRequest !== 1'b0) @(posedge mclk);
    q = avReadData;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    @(posedge mclk);
  endtask
  // One link transaction, then read bytes and the no-ack flag
  task automatic xfer(input logic [1:0] op, input logic [6:0] dv,
                      input logic [7:0] ins, input logic [7:0] dat,
                      input logic two, input logic nk);
    logic [31:0] q;
    av(1'b1, REG_CTRL, {6'h00, op, dat, ins, two, dv}, q);
    st = 32'h1;
    while (st[STAT_BUSY_BIT] !== 1'b0) av(1'b0, REG_STATUS, 32'h0, st);
    av(1'b0, REG_RDATA, 32'h0, rd);
    chk(16'(st[STAT_NACK_BIT]), 16'(nk));
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(16'(wiperPos), 16'h0020);
    chk(16'(storedWiper), 16'h0020);
    tdone("reset");
    xfer(OP_WRITE, DEV, 8'h00, 8'hc5, 1'b0, 1'b0);
    chk(16'(wiperPos), 16'h0005);
    xfer(OP_SETREAD, DEV, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(16'(rd[5:0]), 16'h0005);
    xfer(OP_READ, DEV, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(16'(rd[5:0]), 16'h0005);
    xfer(OP_WRITE, DEV, 8'h20, 8'hff, 1'b0, 1'b0);
    chk(16'(storedWiper), 16'h003f);
    xfer(OP_SETREAD, DEV, 8'h20, 8'h00, 1'b0, 1'b0);
    chk(16'(rd[5:0]), 16'h003f);
    xfer(OP_CMD, DEV, 8'ha0, 8'h00, 1'b0, 1'b0);
    chk(16'(wiperPos), 16'h003f);
    xfer(OP_WRITE, DEV, 8'h00, 8'h4a, 1'b0, 1'b0);
    xfer(OP_CMD, DEV, 8'hc0, 8'h00, 1'b0, 1'b0);
    chk(16'(storedWiper), 16'h000a);
    tdone("latch and store");
    xfer(OP_WRITE, DEV, 8'h40, 8'h01, 1'b0, 1'b0);
    chk(16'(protect), 16'h0001);
    xfer(OP_WRITE, DEV, 8'h20, 8'h11, 1'b0, 1'b0);
    xfer(OP_WRITE, DEV, 8'h00, 8'h15, 1'b0, 1'b0);
    xfer(OP_CMD, DEV, 8'hc0, 8'h00, 1'b0, 1'b0);
    chk(16'(storedWiper), 16'h000a);
    xfer(OP_WRITE, DEV, 8'h40, 8'h00, 1'b0, 1'b0);
    chk(16'(protect), 16'h0000);
    tdone("protect");
    foreach (no_operation[i]) begin
      xfer(OP_WRITE, DEV, no_operation[i], 8'h33, 1'b0, 1'b0);
      chk({4'h0, wiperPos, storedWiper}, 16'h054a);
    end
    tdone("no operation");
    xfer(OP_SETREAD, DEV, 8'h3e, 8'h00, 1'b1, 1'b0);
    chk(rd[15:0], 16'h9c0f);
    xfer(OP_SETREAD, DEV, 8'h3f, 8'h00, 1'b0, 1'b0);
    chk(16'(rd[7:0]), 16'h000f);
    xfer(OP_SETREAD, DEV, 8'h3e, 8'h00, 1'b0, 1'b0);
    chk(16'(rd[7:0]), 16'h009c);
    tdone("tolerance");
    strapHi <= STRAP_LOW;
    xfer(OP_WRITE, DEV, 8'h00, 8'h07, 1'b0, 1'b0);
    chk(16'(wiperPos), 16'h0007);
    xfer(OP_WRITE, 7'h2a, 8'h00, 8'h01, 1'b0, 1'b1);
    chk(16'(wiperPos), 16'h0007);
    tdone("address");
    end_sim();
  end
endmodule
`default_nettype wire
